// file: ptg_pkg.sv
package ptg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_DONE = 12'h524;
    localparam logic [11:0] OFF_IRQ = 12'h528;
    localparam logic [11:0] OFF_CTRL = 12'h52c;
    localparam logic [11:0] OFF_NS = 12'h530;
    localparam logic [11:0] OFF_S = 12'h534;

    // ------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------
    localparam int B_OUT_SEL = 8;
    localparam int B_PIN_IN = 7;
    localparam int B_DIR = 6;
    localparam int B_CIRQ_EN = 5;
    localparam int B_ACTIVE = 4;
    localparam int B_TEN = 3;
    localparam int B_TCLR = 2;
    localparam int B_CEN = 1;
    localparam int B_CCLR = 0;
    localparam int B_TIRQ_LO = 16;
    localparam int NS_W = 30;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_TGT_S = 32'h0000_0000;
    localparam logic [29:0] RST_TGT_NS = 30'h0000_0000;
    localparam logic RST_BIT = 1'b0;
endpackage

// file: ptg_trig_unit.sv
`timescale 1ns/10ps
module ptg_trig_unit
    import ptg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Software commands
    input wire logic start,
    input wire logic stop,
    input wire logic soft_clear,
    input wire logic ns_wr,
    input wire logic s_wr,
    input wire logic [31:0] wdata,
    // Precision time
    input wire logic [31:0] now_s,
    input wire logic [NS_W-1:0] now_ns,
    // Unit state
    output logic en_r,
    output logic hit,
    output logic fire_r,
    output logic [NS_W-1:0] tgt_ns_r,
    output logic [31:0] tgt_s_r
);
    assign hit = en_r && ({now_s, now_ns} >= {tgt_s_r, tgt_ns_r});

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= RST_BIT;
        end else if (soft_clear || hit) begin
            en_r <= 1'b0;
        end else if (start) begin
            en_r <= 1'b1;
        end else if (stop) begin
            en_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fire_r <= 1'b0;
        end else begin
            fire_r <= hit && !soft_clear;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tgt_ns_r <= RST_TGT_NS;
            tgt_s_r <= RST_TGT_S;
        end else if (soft_clear) begin
            tgt_ns_r <= RST_TGT_NS;
            tgt_s_r <= RST_TGT_S;
        end else begin
            if (ns_wr) begin
                tgt_ns_r <= wdata[NS_W-1:0];
            end
            if (s_wr) begin
                tgt_s_r <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_self_clear;
        @(posedge clock) disable iff (!rst_n)
        hit && !soft_clear |=> !en_r ##0 fire_r;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("enable not self cleared");

    property p_trig_clr;
        @(posedge clock) disable iff (!rst_n)
        soft_clear |=> !en_r && tgt_ns_r == RST_TGT_NS && tgt_s_r == RST_TGT_S;
    endproperty
    a_trig_clr: assert property (p_trig_clr) else $error("trigger soft clear failed");
endmodule

// file: ptg_ctrl.sv
`timescale 1ns/10ps
module ptg_ctrl
    import ptg_pkg::*;
#(
    parameter int NUM_TRIG = 3,
    parameter int NUM_CAP = 2,
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_r,
    // Unit index pointers
    input wire logic [1:0] trig_index,
    input wire logic cap_index,
    // Precision time and per-unit options
    input wire logic [31:0] ptp_sec,
    input wire logic [NS_W-1:0] ptp_nsec,
    input wire logic [NUM_TRIG-1:0] trig_notify,
    // Pin
    input wire logic pin_in,
    output logic pin_out_r,
    output logic pin_oe_r,
    // Summary interrupt
    output logic irq_r
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_a_r, rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_a_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n <= rst_a_r;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic ctrl_wr, done_wr, irq_wr, pin_in_d_r, cap_evt;
    logic out_sel_r, pin_dir_r;
    logic [31:0] rd_nxt;
    logic [NUM_TRIG-1:0] t_en, t_hit, t_fire, trig_done_r;
    logic [NS_W-1:0] t_ns [NUM_TRIG];
    logic [31:0] t_s [NUM_TRIG];
    logic [NUM_CAP-1:0] cap_en_r, cap_rdy_r, cap_ovf_r, cap_irq_en_r, cap_irq_r;
    logic [CNT_W-1:0] cap_cnt_r [NUM_CAP];
    assign ctrl_wr = reg_wr_en && reg_addr == OFF_CTRL;
    assign done_wr = reg_wr_en && reg_addr == OFF_DONE;
    assign irq_wr = reg_wr_en && reg_addr == OFF_IRQ;
    // ------------------------------------------------------------
    // Global pin controls
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_sel_r <= RST_BIT;
            pin_dir_r <= RST_BIT;
        end else if (ctrl_wr) begin
            out_sel_r <= reg_wdata[B_OUT_SEL];
            pin_dir_r <= reg_wdata[B_DIR];
        end
    end

    // ------------------------------------------------------------
    // Trigger units
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_TRIG; i++) begin : g_trig
        logic sel;
        assign sel = trig_index == 2'(i);
        ptg_trig_unit u_unit (
            .clock(clock),
            .rst_n(rst_n),
            .start(ctrl_wr && sel && reg_wdata[B_TEN]),
            .stop(ctrl_wr && sel && !reg_wdata[B_TEN]),
            .soft_clear(ctrl_wr && sel && reg_wdata[B_TCLR]),
            .ns_wr(reg_wr_en && reg_addr == OFF_NS && sel),
            .s_wr(reg_wr_en && reg_addr == OFF_S && sel),
            .wdata(reg_wdata),
            .now_s(ptp_sec),
            .now_ns(ptp_nsec),
            .en_r(t_en[i]),
            .hit(t_hit[i]),
            .fire_r(t_fire[i]),
            .tgt_ns_r(t_ns[i]),
            .tgt_s_r(t_s[i])
        );
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                trig_done_r[i] <= 1'b0;
            end else if (t_fire[i] && trig_notify[i]) begin
                trig_done_r[i] <= 1'b1;
            end else if ((done_wr && reg_wdata[i]) || (irq_wr && reg_wdata[B_TIRQ_LO+i])) begin
                trig_done_r[i] <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // Pin output
    // ------------------------------------------------------------
    // path select
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_r <= 1'b0;
        end else if (pin_dir_r) begin
            pin_out_r <= 1'b0;
        end else begin
            pin_out_r <= out_sel_r ? |t_hit : |t_fire;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_r <= 1'b0;
        end else begin
            pin_oe_r <= !pin_dir_r;
        end
    end
    // ------------------------------------------------------------
    // Capture units
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_in_d_r <= 1'b0;
        end else begin
            pin_in_d_r <= pin_in;
        end
    end
    assign cap_evt = pin_dir_r && pin_in && !pin_in_d_r;
    for (genvar j = 0; j < NUM_CAP; j++) begin : g_cap
        logic wr, clr, hitc;
        assign wr = ctrl_wr && cap_index == 1'(j);
        assign clr = wr && reg_wdata[B_CCLR];
        assign hitc = cap_en_r[j] && cap_evt;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cap_en_r[j] <= RST_BIT;
                cap_irq_en_r[j] <= RST_BIT;
            end else if (clr) begin
                cap_en_r[j] <= RST_BIT;
                cap_irq_en_r[j] <= RST_BIT;
            end else if (wr) begin
                cap_en_r[j] <= reg_wdata[B_CEN];
                cap_irq_en_r[j] <= reg_wdata[B_CIRQ_EN];
            end
        end
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cap_cnt_r[j] <= '0;
            end else if (clr || (wr && reg_wdata[B_CEN])) begin
                cap_cnt_r[j] <= '0;
            end else if (hitc && cap_cnt_r[j] != '1) begin
                cap_cnt_r[j] <= cap_cnt_r[j] + 1'b1;
            end
        end
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cap_rdy_r[j] <= 1'b0;
                cap_ovf_r[j] <= 1'b0;
            end else if (clr || (wr && !reg_wdata[B_CEN])) begin
                cap_rdy_r[j] <= 1'b0;
                cap_ovf_r[j] <= 1'b0;
            end else if (hitc) begin
                cap_rdy_r[j] <= 1'b1;
                if (cap_cnt_r[j] == '1) begin
                    cap_ovf_r[j] <= 1'b1;
                end
            end
        end
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cap_irq_r[j] <= 1'b0;
            end else if (hitc && cap_irq_en_r[j]) begin
                cap_irq_r[j] <= 1'b1;
            end else if (irq_wr && reg_wdata[j]) begin
                cap_irq_r[j] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Summary interrupt
    // ------------------------------------------------------------
    // OR of status
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |{trig_done_r, cap_irq_r};
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0;
        unique case (reg_addr)
            OFF_CTRL: begin
                rd_nxt[B_OUT_SEL] = out_sel_r;
                rd_nxt[B_PIN_IN] = pin_in;
                rd_nxt[B_DIR] = pin_dir_r;
                rd_nxt[B_CIRQ_EN] = cap_irq_en_r[cap_index];
                rd_nxt[B_CEN] = cap_en_r[cap_index];
                if (32'(trig_index) < NUM_TRIG) begin
                    rd_nxt[B_ACTIVE] = t_en[trig_index];
                    rd_nxt[B_TEN] = t_en[trig_index];
                end
            end
            OFF_NS: begin
                if (32'(trig_index) < NUM_TRIG) begin
                    rd_nxt[NS_W-1:0] = t_ns[trig_index];
                end
            end
            OFF_S: begin
                if (32'(trig_index) < NUM_TRIG) begin
                    rd_nxt = t_s[trig_index];
                end
            end
            OFF_DONE: rd_nxt[NUM_TRIG-1:0] = trig_done_r;
            OFF_IRQ: begin
                rd_nxt[B_TIRQ_LO +: NUM_TRIG] = trig_done_r;
                rd_nxt[NUM_CAP-1:0] = cap_irq_r;
            end
            default: rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 32'h0;
        end else if (reg_rd_en) begin
            reg_rdata_r <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_ctrl_wr;
        reg_wr_en && reg_addr == OFF_CTRL;
    endsequence
    sequence s_start0;
        s_ctrl_wr ##0 (trig_index == 2'h0 && reg_wdata[B_TEN] && !reg_wdata[B_TCLR]);
    endsequence
    sequence s_fire_notify0;
        t_fire[0] && trig_notify[0];
    endsequence
    property p_route;
        s_start0 ##0 (!t_hit[0] && !t_hit[1]) |=> t_en[0] && t_en[1] == $past(t_en[1]);
    endproperty
    a_route: assert property (p_route) else $error("trigger enable misrouted");
    property p_out_path;
        !out_sel_r && !pin_dir_r |=> pin_out_r == $past(|t_fire);
    endproperty
    a_out_path: assert property (p_out_path) else $error("registered path wrong");
    property p_pin_read;
        reg_rd_en && reg_addr == OFF_CTRL |=> reg_rdata_r[B_PIN_IN] == $past(pin_in);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level misread");
    property p_dir;
        s_ctrl_wr ##0 reg_wdata[B_DIR] |=> ##1 !pin_oe_r && !pin_out_r;
    endproperty
    a_dir: assert property (p_dir) else $error("pin still driven as input");
    property p_irq_gate;
        !cap_irq_en_r[0] && !cap_irq_r[0] |=> !cap_irq_r[0];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("capture irq not gated");
    property p_cap_en;
        s_ctrl_wr ##0 (!cap_index && reg_wdata[B_CEN] && !reg_wdata[B_CCLR])
            |=> cap_en_r[0] && cap_cnt_r[0] == '0;
    endproperty
    a_cap_en: assert property (p_cap_en) else $error("capture enable failed");
    property p_cap_dis;
        s_ctrl_wr ##0 (!cap_index && !reg_wdata[B_CEN])
            |=> !cap_en_r[0] && !cap_rdy_r[0] && !cap_ovf_r[0];
    endproperty
    a_cap_dis: assert property (p_cap_dis) else $error("capture disable failed");
    property p_ns_rsvd;
        reg_rd_en && reg_addr == OFF_NS |=> reg_rdata_r[31:NS_W] == 2'h0;
    endproperty
    a_ns_rsvd: assert property (p_ns_rsvd) else $error("reserved ns bits set");
    property p_done;
        s_fire_notify0 |=> trig_done_r[0] ##1 irq_r;
    endproperty
    a_done: assert property (p_done) else $error("done status missing");
    property p_summary;
        ##1 irq_r == $past(|{trig_done_r, cap_irq_r});
    endproperty
    a_summary: assert property (p_summary) else $error("summary irq wrong");
endmodule

// file: ptg_far_end.sv
`timescale 1ns/10ps
module ptg_far_end
    import ptg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Time control
    input wire logic run,
    input wire logic load,
    input wire logic [31:0] load_s,
    input wire logic [NS_W-1:0] load_ns,
    // Pin wire
    input wire logic ext_level,
    input wire logic pin_out,
    input wire logic pin_oe,
    // To the device
    output logic [31:0] ptp_sec,
    output logic [NS_W-1:0] ptp_nsec,
    output logic pin_in
);
    // ----------------------------------------
    // Precision time, 10 ns per cycle
    // ----------------------------------------
    // seconds major rollover
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptp_sec <= 32'h0;
            ptp_nsec <= '0;
        end else if (load) begin
            ptp_sec <= load_s;
            ptp_nsec <= load_ns;
        end else if (run) begin
            if (ptp_nsec >= 30'h3b9ac9f6) begin
                ptp_sec <= ptp_sec + 32'h1;
                ptp_nsec <= '0;
            end else begin
                ptp_nsec <= ptp_nsec + 30'ha;
            end
        end
    end

    // ----------------------------------------
    // Pin level
    // ----------------------------------------
    // driven pin wins
    assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb
    import ptg_pkg::*;
;
    logic clock, nrst, reg_wr_en, reg_rd_en, cap_index, ext_level, run, load;
    logic pin_in, pin_out_r, pin_oe_r, irq_r;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_r, ptp_sec, load_s;
    logic [1:0] trig_index;
    logic [NS_W-1:0] ptp_nsec, load_ns;
    logic [2:0] trig_notify;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int lat[2];

    ptg_ctrl #(.NUM_TRIG(3), .NUM_CAP(2), .CNT_W(4)) uut (
        .clock(clock), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .trig_index(trig_index), .cap_index(cap_index), .ptp_sec(ptp_sec),
        .ptp_nsec(ptp_nsec), .trig_notify(trig_notify), .pin_in(pin_in),
        .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .irq_r(irq_r));

    ptg_far_end far (
        .clock(clock), .rst_n(nrst), .run(run), .load(load), .load_s(load_s),
        .load_ns(load_ns), .ext_level(ext_level), .pin_out(pin_out_r),
        .pin_oe(pin_oe_r), .ptp_sec(ptp_sec), .ptp_nsec(ptp_nsec), .pin_in(pin_in));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        chk(nm, e, reg_rdata_r);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic set_time(input logic [31:0] s, input logic [NS_W-1:0] ns);
        @(negedge clock);
        load = 1'b1;
        load_s = s;
        load_ns = ns;
        @(negedge clock);
        load = 1'b0;
    endtask

    task automatic wait_fire(output int c);
        c = 0;
        while (pin_out_r !== 1'b1 && c < 200) begin
            @(negedge clock);
            c++;
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d checked, %0d errors", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {nrst, reg_wr_en, reg_rd_en, cap_index, ext_level, run, load} = '0;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        load_s = 32'h0;
        load_ns = '0;
        trig_index = 2'h0;
        trig_notify = 3'h3;
        tick(3);
        nrst = 1'b1;
        tick(4);
        chk("pin_oe_r", 32'h1, {31'h0, pin_oe_r});
        chk_rd("ns reset", OFF_NS, 32'h0);
        chk_rd("s reset", OFF_S, 32'h0);
        chk_rd("ctrl reset", OFF_CTRL, 32'h0);
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            trig_index = i[1:0];
            wr(OFF_NS, 32'hffff_fff0 | i);
            wr(OFF_S, 32'h1000_0000 + i);
        end
        for (int i = 0; i < 4; i++) begin
            trig_index = i[1:0];
            chk_rd("ns bank", OFF_NS, i < 3 ? 32'h3fff_fff0 | i : 32'h0);
            chk_rd("s bank", OFF_S, i < 3 ? 32'h1000_0000 + i : 32'h0);
        end
        chk_rd("unmapped", 12'h600, 32'h0);
        $display("test banking done");

        set_time(32'h5, 30'h64);
        for (int k = 0; k < 2; k++) begin
            trig_index = k ? 2'h2 : 2'h0;
            wr(OFF_NS, 32'h64);
            wr(OFF_S, 32'h5);
            wr(OFF_CTRL, k ? 32'h8 : 32'h108);
            wait_fire(lat[k]);
            tick(1);
            chk("pulse width", 32'h0, {31'h0, pin_out_r});
        end
        chk("path delta", 32'h1, 32'(lat[1] - lat[0]));
        chk_rd("ctrl after fire", OFF_CTRL, 32'h0);
        $display("test fire done");

        trig_index = 2'h1;
        set_time(32'h5, 30'h3b9a_c618);
        wr(OFF_NS, 32'h0);
        wr(OFF_S, 32'h6);
        wr(OFF_CTRL, 32'h8);
        run = 1'b1;
        wait_fire(lat[0]);
        run = 1'b0;
        chk("wait window", 32'h1, {31'h0, lat[0] > 90 && lat[0] < 110});
        $display("test rollover done");

        tick(3);
        chk("irq", 32'h1, {31'h0, irq_r});
        chk_rd("done", OFF_DONE, 32'h3);
        chk_rd("status", OFF_IRQ, 32'h3_0000);
        wr(OFF_IRQ, 32'h1_0000);
        chk_rd("done part", OFF_DONE, 32'h2);
        wr(OFF_DONE, 32'h2);
        tick(2);
        chk_rd("done clear", OFF_DONE, 32'h0);
        chk("irq clear", 32'h0, {31'h0, irq_r});
        $display("test done status done");

        wr(OFF_S, 32'h9);
        wr(OFF_CTRL, 32'h8);
        chk_rd("active", OFF_CTRL, 32'h18);
        wr(OFF_CTRL, 32'h4);
        chk_rd("soft clear", OFF_CTRL, 32'h0);
        chk_rd("soft clear s", OFF_S, 32'h0);
        $display("test trigger clear done");

        cap_index = 1'b1;
        wr(OFF_CTRL, 32'h62);
        tick(2);
        chk("oe input", 32'h0, {31'h0, pin_oe_r});
        chk_rd("ctrl input", OFF_CTRL, 32'h62);
        ext_level = 1'b1;
        tick(3);
        chk("cap irq", 32'h1, {31'h0, irq_r});
        chk_rd("cap status", OFF_IRQ, 32'h2);
        chk_rd("pin level", OFF_CTRL, 32'he2);
        ext_level = 1'b0;
        wr(OFF_IRQ, 32'h2);
        tick(2);
        chk("cap irq clear", 32'h0, {31'h0, irq_r});
        chk_rd("cap clear", OFF_IRQ, 32'h0);
        wr(OFF_CTRL, 32'h41);
        chk_rd("cap soft", OFF_CTRL, 32'h40);
        cap_index = 1'b0;
        chk_rd("cap bank", OFF_CTRL, 32'h40);
        wr(OFF_CTRL, 32'h42);
        ext_level = 1'b1;
        tick(3);
        chk("gated irq", 32'h0, {31'h0, irq_r});
        chk_rd("gated status", OFF_IRQ, 32'h0);
        chk_rd("cap0 input", OFF_CTRL, 32'hc2);
        ext_level = 1'b0;
        $display("test capture done");
        wrap_up();
    end
endmodule
